/* core/cso_pkg.sv */
// Constants, field layout and state encoding of the calibration offset and
// overvoltage response register block.
// Assumes a 100 MHz device clock and one command per strobe from the link logic.
package cso_pkg;

  // ---------------------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CSO_CMD_CAL_OFFSET = 8'h39;
  localparam logic [7:0] CSO_CMD_OV_ACTION = 8'h41;
  localparam logic [7:0] CSO_CMD_STORE_ALL = 8'h11;

  // ---------------------------------------------------------------------------
  // Reset values and field layout
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CSO_CAL_RESET = 16'he000;
  localparam logic [7:0] CSO_OV_RESET = 8'hbf;
  localparam logic [4:0] CSO_CAL_EXP = 5'h1c;
  localparam int CSO_CAL_SIGN_BIT = 10;
  localparam int CSO_CAL_EXP_LSB = 11;
  localparam int CSO_CAL_LOW_W = 6;
  localparam int CSO_CAL_EXT_W = 4;
  localparam int CSO_OV_RSP_BIT = 7;
  localparam int CSO_OV_RS_LSB = 3;
  localparam int CSO_OV_RS_MSB = 5;
  localparam logic [2:0] CSO_RS_NEVER = 3'h0;
  localparam logic [2:0] CSO_RS_ALWAYS = 3'h7;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CSO_CLK_PERIOD_NS = 10;
  localparam int CSO_RISE_TIME_US = 3000;
  localparam int CSO_RETRY_RISE_TIMES = 7;

  typedef enum logic [1:0] {
    CSO_ST_RUN = 2'h0,
    CSO_ST_OFF = 2'h1,
    CSO_ST_WAIT = 2'h3,
    CSO_ST_SOFT = 2'h2
  } cso_seq_state_t;

endpackage : cso_pkg

/* core/cso_ov_if.sv */
// Signals between the register block and the overvoltage response sequencer.
// Assumes both ends run on the same device clock.
`timescale 1ns/1ps
`default_nettype none
interface cso_ov_if;
  logic resp_sel;
  logic retry_en;
  logic ov_fault;
  logic fault_clear;
  logic run_on;
  logic out_en;
  logic soft_start;

  modport ctrl (
    output resp_sel,
    output retry_en,
    output ov_fault,
    output fault_clear,
    output run_on,
    input out_en,
    input soft_start
  );

  modport seq (
    input resp_sel,
    input retry_en,
    input ov_fault,
    input fault_clear,
    input run_on,
    output out_en,
    output soft_start
  );
endinterface : cso_ov_if
`default_nettype wire

/* core/cso_ov_seq.sv */
// Overvoltage response sequencer: shutdown, retry wait and soft start.
// Assumes a synchronised fault level and a one-cycle fault clear pulse.
`timescale 1ns/1ps
`default_nettype none
module cso_ov_seq
  import cso_pkg::*;
#(
  parameter int unsigned RISE_CYCLES = 300000
) (
  input wire logic clk,
  input wire logic arst_n,
  cso_ov_if.seq ov
);

  localparam logic [31:0] SOFT_LAST = 32'(RISE_CYCLES - 1);
  localparam logic [31:0] WAIT_LAST = 32'(CSO_RETRY_RISE_TIMES * RISE_CYCLES - 1);

  cso_seq_state_t state_q;
  cso_seq_state_t state_d;
  logic [31:0] cnt_q;
  logic trip;

  assign trip = ov.ov_fault && ov.resp_sel;

  // ---------------------------------------------------------------------------
  // State sequence
  // ---------------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      CSO_ST_RUN:
        if (trip) state_d = CSO_ST_OFF;
      CSO_ST_OFF:
        if (ov.fault_clear || !ov.run_on) state_d = CSO_ST_RUN;
        else if (ov.retry_en) state_d = CSO_ST_WAIT;
      CSO_ST_WAIT:
        if (!ov.run_on) state_d = CSO_ST_RUN;
        else if (cnt_q == WAIT_LAST) state_d = CSO_ST_SOFT;
      CSO_ST_SOFT:
        if (trip) state_d = CSO_ST_OFF;
        else if (!ov.run_on || cnt_q == SOFT_LAST) state_d = CSO_ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) state_q <= CSO_ST_RUN;
    else state_q <= state_d;
  end

  // Counts clock cycles while waiting and during soft start, zeroed on each move.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) cnt_q <= 32'h0000_0000;
    else if (state_d != state_q || state_q == CSO_ST_RUN || state_q == CSO_ST_OFF)
      cnt_q <= 32'h0000_0000;
    else cnt_q <= cnt_q + 32'h0000_0001;
  end

  assign ov.out_en = ov.run_on && (state_q == CSO_ST_RUN || state_q == CSO_ST_SOFT);
  assign ov.soft_start = state_q == CSO_ST_SOFT;

  ignore_mode_run_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CSO_ST_RUN && !ov.resp_sel |=> state_q == CSO_ST_RUN)
    else $error("ignore mode left the run state");

  shutdown_on_ov_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CSO_ST_RUN && trip |=> state_q == CSO_ST_OFF ##0 !ov.out_en)
    else $error("overvoltage in shutdown mode did not disable output");

  latched_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CSO_ST_OFF && !ov.retry_en && !ov.fault_clear && ov.run_on
    |=> state_q == CSO_ST_OFF)
    else $error("latched-off state left without a fault clear");

  retry_wait_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CSO_ST_WAIT && ov.run_on
    |=> (state_q == CSO_ST_WAIT && cnt_q == $past(cnt_q) + 32'h0000_0001)
    || (state_q == CSO_ST_SOFT && $past(cnt_q) == WAIT_LAST))
    else $error("retry wait not equal to seven rise times");

endmodule : cso_ov_seq
`default_nettype wire

/* core/cso_regs.sv */
// Calibration offset and overvoltage response registers with status and alert.
// Assumes the link logic presents decoded commands as one-cycle strobes on the
// device clock, and that the fault and loop-slave pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module cso_regs
  import cso_pkg::*;
#(
  parameter int unsigned RISE_CYCLES = CSO_RISE_TIME_US * 1000 / CSO_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_rsp_valid,
  output logic cmd_ack,
  output logic [15:0] cmd_rdata,
  input wire logic clear_faults,
  input wire logic ov_alert_mask,
  input wire logic loop_slave_pin,
  input wire logic ov_fault_pin,
  input wire logic op_on,
  input wire logic [15:0] iout_raw,
  input wire logic [15:0] oc_fault_base,
  input wire logic [15:0] oc_warn_base,
  output logic [15:0] output_current_telemetry,
  output logic [15:0] overcurrent_fault_threshold,
  output logic [15:0] overcurrent_warning_threshold,
  input wire logic nvm_load,
  input wire logic [6:0] nvm_cal_in,
  input wire logic [1:0] nvm_ov_in,
  output logic nvm_store,
  output logic [6:0] nvm_cal_out,
  output logic [1:0] nvm_ov_out,
  output logic status_byte_ov,
  output logic status_byte_cml,
  output logic status_word_vout,
  output logic output_voltage_status_ov,
  output logic status_cml_ivd,
  output logic invalid_command_fault,
  output logic output_enable,
  output logic soft_start_active,
  input wire logic smbalert_i,
  output logic smbalert_o,
  output logic smbalert_oe_n
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic loop_slave;
  logic ov_fault;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end
    else
    begin
      pin_meta_q <= {loop_slave_pin, ov_fault_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign loop_slave = pin_sync_q[1];
  assign ov_fault = pin_sync_q[0];

  // ---------------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------------
  logic is_cal;
  logic is_ov;
  logic is_store;
  logic ov_locked;
  logic ov_bad;
  logic wr_cal;
  logic wr_ov_ok;
  logic wr_ov_bad;
  logic [2:0] rs_field;

  assign is_cal = cmd_code == CSO_CMD_CAL_OFFSET;
  assign is_ov = cmd_code == CSO_CMD_OV_ACTION;
  assign is_store = cmd_code == CSO_CMD_STORE_ALL;
  assign rs_field = cmd_wdata[CSO_OV_RS_MSB:CSO_OV_RS_LSB];
  assign ov_bad = rs_field != CSO_RS_NEVER && rs_field != CSO_RS_ALWAYS;
  assign ov_locked = cmd_valid && is_ov && loop_slave;
  assign wr_cal = cmd_valid && cmd_write && is_cal;
  assign wr_ov_ok = cmd_valid && cmd_write && is_ov && !loop_slave && !ov_bad;
  assign wr_ov_bad = cmd_valid && cmd_write && is_ov && !loop_slave && ov_bad;

  // ---------------------------------------------------------------------------
  // Calibration offset register
  // ---------------------------------------------------------------------------
  logic cal_sign_q;
  logic [CSO_CAL_LOW_W-1:0] cal_low_q;
  logic [15:0] cal_word;
  logic [15:0] cal_ext;

  // Only the sign and the low bits are stored, so bits 9:6 of any value written are dropped.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cal_sign_q <= CSO_CAL_RESET[CSO_CAL_SIGN_BIT];
      cal_low_q <= CSO_CAL_RESET[CSO_CAL_LOW_W-1:0];
    end
    else if (wr_cal)
    begin
      cal_sign_q <= cmd_wdata[CSO_CAL_SIGN_BIT];
      cal_low_q <= cmd_wdata[CSO_CAL_LOW_W-1:0];
    end
    else if (nvm_load)
    begin
      cal_sign_q <= nvm_cal_in[CSO_CAL_LOW_W];
      cal_low_q <= nvm_cal_in[CSO_CAL_LOW_W-1:0];
    end
  end

  // Offset in 62.5 mA steps as a 16-bit two's complement value.
  assign cal_ext = {{(16 - CSO_CAL_LOW_W){cal_sign_q}}, cal_low_q};
  assign cal_word = {CSO_CAL_EXP, cal_sign_q, {CSO_CAL_EXT_W{cal_sign_q}}, cal_low_q};

  // ---------------------------------------------------------------------------
  // Overvoltage response register
  // ---------------------------------------------------------------------------
  logic resp_sel_q;
  logic retry_q;
  logic [7:0] ov_word;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      resp_sel_q <= CSO_OV_RESET[CSO_OV_RSP_BIT];
      retry_q <= CSO_OV_RESET[CSO_OV_RS_MSB];
    end
    else if (wr_ov_ok)
    begin
      resp_sel_q <= cmd_wdata[CSO_OV_RSP_BIT];
      retry_q <= cmd_wdata[CSO_OV_RS_MSB];
    end
    else if (nvm_load)
    begin
      resp_sel_q <= nvm_ov_in[1];
      retry_q <= nvm_ov_in[0];
    end
  end

  assign ov_word = {resp_sel_q, 1'b0, {3{retry_q}}, {3{retry_q}}};

  // ---------------------------------------------------------------------------
  // Command response
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_rsp_valid <= 1'b0;
      cmd_ack <= 1'b0;
      cmd_rdata <= 16'h0000;
    end
    else
    begin
      cmd_rsp_valid <= cmd_valid;
      cmd_ack <= cmd_valid && (is_cal || (is_ov && !loop_slave) || is_store);
      if (cmd_valid && !cmd_write && is_cal) cmd_rdata <= cal_word;
      else if (cmd_valid && !cmd_write && is_ov && !loop_slave) cmd_rdata <= {8'h00, ov_word};
      else cmd_rdata <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Nonvolatile store
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nvm_store <= 1'b0;
      nvm_cal_out <= 7'h00;
      nvm_ov_out <= 2'h0;
    end
    else
    begin
      nvm_store <= cmd_valid && cmd_write && is_store;
      if (cmd_valid && cmd_write && is_store)
      begin
        nvm_cal_out <= {cal_sign_q, cal_low_q};
        nvm_ov_out <= {resp_sel_q, retry_q};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sticky status flags, a new event wins over a clear in the same cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_byte_ov <= 1'b0;
      status_word_vout <= 1'b0;
      output_voltage_status_ov <= 1'b0;
    end
    else if (ov_fault)
    begin
      status_byte_ov <= 1'b1;
      status_word_vout <= 1'b1;
      output_voltage_status_ov <= 1'b1;
    end
    else if (clear_faults)
    begin
      status_byte_ov <= 1'b0;
      status_word_vout <= 1'b0;
      output_voltage_status_ov <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_byte_cml <= 1'b0;
      status_cml_ivd <= 1'b0;
      invalid_command_fault <= 1'b0;
    end
    else
    begin
      status_byte_cml <= wr_ov_bad || ov_locked || (status_byte_cml && !clear_faults);
      status_cml_ivd <= wr_ov_bad || (status_cml_ivd && !clear_faults);
      invalid_command_fault <= ov_locked || (invalid_command_fault && !clear_faults);
    end
  end

  // The alert pin is pulled low while any unmasked status is pending.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) smbalert_oe_n <= 1'b1;
    else smbalert_oe_n <= !(status_byte_cml || status_cml_ivd || invalid_command_fault ||
      ((status_byte_ov || output_voltage_status_ov) && !ov_alert_mask));
  end

  assign smbalert_o = 1'b0;

  // ---------------------------------------------------------------------------
  // Offset correction of telemetry and thresholds
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      output_current_telemetry <= 16'h0000;
      overcurrent_fault_threshold <= 16'h0000;
      overcurrent_warning_threshold <= 16'h0000;
    end
    else
    begin
      output_current_telemetry <= 16'(iout_raw + cal_ext);
      overcurrent_fault_threshold <= 16'(oc_fault_base + cal_ext);
      overcurrent_warning_threshold <= 16'(oc_warn_base + cal_ext);
    end
  end

  // ---------------------------------------------------------------------------
  // Overvoltage response sequencer
  // ---------------------------------------------------------------------------
  cso_ov_if ov_if ();

  assign ov_if.resp_sel = resp_sel_q;
  assign ov_if.retry_en = retry_q;
  assign ov_if.ov_fault = ov_fault;
  assign ov_if.fault_clear = clear_faults;
  assign ov_if.run_on = op_on;

  cso_ov_seq #(
    .RISE_CYCLES(RISE_CYCLES)
  ) u_seq (
    .clk(clk),
    .arst_n(arst_n),
    .ov(ov_if.seq)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      output_enable <= 1'b0;
      soft_start_active <= 1'b0;
    end
    else
    begin
      output_enable <= ov_if.out_en;
      soft_start_active <= ov_if.soft_start;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  offset_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_valid && !cmd_write && is_cal |=> cmd_ack && cmd_rdata[15:11] == CSO_CAL_EXP
    && cmd_rdata[9:6] == {4{cmd_rdata[10]}})
    else $error("offset read returned a bad fixed field");

  offset_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_cal |=> cal_sign_q == $past(cmd_wdata[10]) && cal_low_q == $past(cmd_wdata[5:0]))
    else $error("offset write not stored");

  offset_no_err_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_cal |=> !$rose(status_byte_cml) && !$rose(status_cml_ivd))
    else $error("offset write raised an error");

  ov_reject_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_ov_bad |=> status_byte_cml && status_cml_ivd && $stable(resp_sel_q) && $stable(retry_q)
    ##1 !smbalert_oe_n)
    else $error("bad retry setting not rejected");

  loop_nack_a: assert property (@(posedge clk) disable iff (!arst_n)
    ov_locked |=> cmd_rsp_valid && !cmd_ack && invalid_command_fault && $stable(resp_sel_q))
    else $error("loop slave access not refused");

  delay_mirror_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_valid && !cmd_write && is_ov && !loop_slave |=> cmd_rdata[2:0] == cmd_rdata[5:3]
    && cmd_rdata[6] == 1'b0)
    else $error("retry delay does not mirror retry setting");

  ov_status_a: assert property (@(posedge clk) disable iff (!arst_n)
    ov_fault && !ov_alert_mask |=> status_byte_ov && status_word_vout
    && output_voltage_status_ov ##1 !smbalert_oe_n)
    else $error("overvoltage status or alert missing");

  telemetry_ofs_a: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> output_current_telemetry == 16'($past(iout_raw) + $past(cal_ext)))
    else $error("telemetry not corrected by offset");

endmodule : cso_regs
`default_nettype wire

/* testbench/cso_host_model.sv */
// Host side of the command port: issues one read or write at a time.
// Assumes the answer is registered and appears one cycle after the command.
`timescale 1ns/1ps
`default_nettype none
module cso_host_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic cmd_rsp_valid,
  input wire logic cmd_ack,
  input wire logic [15:0] cmd_rdata
);
  initial
  begin
    cmd_valid = 1'h0;
    cmd_write = 1'h0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // Idle lines carry the inverse of the last command so stale data never matches.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic rv, output logic ack, output logic [15:0] rd);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'h0;
    cmd_write <= ~wr;
    cmd_code <= ~code;
    cmd_wdata <= ~wd;
    #1;
    rv = cmd_rsp_valid;
    ack = cmd_ack;
    rd = cmd_rdata;
  endtask : xfer
endmodule : cso_host_model
`default_nettype wire

/* testbench/current_offset_ov_response_regs_tb.sv */
// Self-checking bench for the offset and overvoltage response registers.
// Assumes a shortened rise time of 4 cycles and an alert wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module current_offset_ov_response_regs_tb;
  import cso_pkg::*;
  localparam int RC = 4;
  logic clk, arst_n, cmd_valid, cmd_write, rv, ak, clear_faults, ov_alert_mask;
  logic loop_slave_pin, ov_fault_pin, op_on, nvm_load, nvm_store, cmd_rsp_valid, cmd_ack;
  logic status_byte_ov, status_byte_cml, status_word_vout, output_voltage_status_ov;
  logic status_cml_ivd, invalid_command_fault, output_enable, soft_start_active;
  logic smbalert_o, smbalert_oe_n, ok, seen;
  wire logic smbalert_i;
  logic [7:0] cmd_code, cur;
  logic [15:0] cmd_wdata, cmd_rdata, rd, wd, seed, iout_raw, oc_fault_base, oc_warn_base;
  logic [15:0] output_current_telemetry, overcurrent_fault_threshold;
  logic [15:0] overcurrent_warning_threshold;
  logic [6:0] nvm_cal_in, nvm_cal_out;
  logic [1:0] nvm_ov_in, nvm_ov_out;
  int n_fail, checked, cyc, n;
  logic [15:0] corner [3] = '{16'h07ff, 16'hf800, 16'h0400};

  assign smbalert_i = smbalert_oe_n ? 1'h1 : smbalert_o;

  cso_regs #(.RISE_CYCLES(RC)) cso_regs_i (.clk(clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rsp_valid(cmd_rsp_valid), .cmd_ack(cmd_ack),
    .cmd_rdata(cmd_rdata), .clear_faults(clear_faults), .ov_alert_mask(ov_alert_mask),
    .loop_slave_pin(loop_slave_pin), .ov_fault_pin(ov_fault_pin), .op_on(op_on),
    .iout_raw(iout_raw), .oc_fault_base(oc_fault_base), .oc_warn_base(oc_warn_base),
    .output_current_telemetry(output_current_telemetry),
    .overcurrent_fault_threshold(overcurrent_fault_threshold),
    .overcurrent_warning_threshold(overcurrent_warning_threshold),
    .nvm_load(nvm_load), .nvm_cal_in(nvm_cal_in), .nvm_ov_in(nvm_ov_in),
    .nvm_store(nvm_store), .nvm_cal_out(nvm_cal_out), .nvm_ov_out(nvm_ov_out),
    .status_byte_ov(status_byte_ov), .status_byte_cml(status_byte_cml),
    .status_word_vout(status_word_vout),
    .output_voltage_status_ov(output_voltage_status_ov), .status_cml_ivd(status_cml_ivd),
    .invalid_command_fault(invalid_command_fault), .output_enable(output_enable),
    .soft_start_active(soft_start_active), .smbalert_i(smbalert_i),
    .smbalert_o(smbalert_o), .smbalert_oe_n(smbalert_oe_n));

  cso_host_model cso_host_model_i (.clk(clk), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rsp_valid(cmd_rsp_valid), .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  function automatic logic [15:0] exp_cal(input logic [15:0] w);
    return {5'h1c, {5{w[10]}}, w[5:0]};
  endfunction : exp_cal

  function automatic logic [15:0] ext(input logic [15:0] w);
    return {{10{w[10]}}, w[5:0]};
  endfunction : ext

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wt

  task automatic c(input logic w, input logic [7:0] k, input logic [15:0] d);
    cso_host_model_i.xfer(w, k, d, rv, ak, rd);
    chk(rv, 16'h0001);
  endtask : c

  task automatic clr();
    clear_faults <= 1'h1;
    wt(1);
    clear_faults <= 1'h0;
    wt(3);
  endtask : clr

  task automatic fault(input int k);
    ov_fault_pin <= 1'h1;
    wt(k);
  endtask : fault

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    {arst_n, clear_faults, ov_alert_mask, loop_slave_pin, ov_fault_pin} = 5'h00;
    {nvm_load, nvm_cal_in, nvm_ov_in} = 10'h000;
    {iout_raw, oc_fault_base, oc_warn_base} = 48'h0;
    op_on = 1'h1;
    seed = 16'hf2a5;
    wt(10);
    chk(smbalert_oe_n, 16'h0001);
    arst_n <= 1'h1;
    c(0, CSO_CMD_CAL_OFFSET, 16'h0000);
    chk(rd, 16'he000);
    c(0, CSO_CMD_OV_ACTION, 16'h0000);
    chk(rd, 16'h00bf);
    for (int i = 0; i < 28; i++)
    begin
      seed = lfsr(seed);
      wd = (i < 3) ? corner[i] : seed;
      c(1, CSO_CMD_CAL_OFFSET, wd);
      chk(ak, 16'h0001);
      seed = lfsr(seed);
      iout_raw <= seed;
      oc_fault_base <= ~seed;
      oc_warn_base <= {seed[7:0], seed[15:8]};
      c(0, CSO_CMD_CAL_OFFSET, 16'h0000);
      chk(rd, exp_cal(wd));
      chk(output_current_telemetry, iout_raw + ext(wd));
      chk(overcurrent_fault_threshold, oc_fault_base + ext(wd));
      chk(overcurrent_warning_threshold, oc_warn_base + ext(wd));
    end
    chk(status_byte_cml, 16'h0000);
    cur = 8'hbf;
    for (int i = 0; i < 8; i++)
    begin
      clr();
      ok = (i == 0 || i == 7);
      c(1, CSO_CMD_OV_ACTION, {8'h00, 2'h3, i[2:0], 3'h2});
      if (ok)
        cur = {2'h2, i[2:0], i[2:0]};
      wt(2);
      chk(smbalert_oe_n, {15'h0, ok});
      chk(status_cml_ivd, {15'h0, !ok});
      chk(status_byte_cml, {15'h0, !ok});
      c(0, CSO_CMD_OV_ACTION, 16'h0000);
      chk(rd, {8'h00, cur});
    end
    clr();
    for (int r = 0; r < 2; r++)
    begin
      fault(5);
      chk({status_byte_ov, status_word_vout, output_voltage_status_ov}, 16'h0007);
      chk({smbalert_oe_n, output_enable}, 16'h0000);
      ov_fault_pin <= 1'h0;
      n = 0;
      seen = 1'h0;
      while (output_enable !== 1'h1 && n < 100)
      begin
        seen |= soft_start_active;
        n++;
        wt(1);
      end
      chk(n >= 7 * RC - 2 && n <= 8 * RC + 8, 16'h0001);
      chk({seen, soft_start_active}, 16'h0001);
    end
    c(1, CSO_CMD_OV_ACTION, 16'h0080);
    fault(5);
    ov_fault_pin <= 1'h0;
    wt(60);
    chk(output_enable, 16'h0000);
    clr();
    chk(output_enable, 16'h0001);
    c(1, CSO_CMD_OV_ACTION, 16'h0000);
    fault(6);
    chk({output_enable, status_byte_ov, smbalert_oe_n, smbalert_i}, 16'h000c);
    ov_fault_pin <= 1'h0;
    wt(3);
    ov_alert_mask <= 1'h1;
    clr();
    fault(6);
    chk({output_voltage_status_ov, smbalert_oe_n}, 16'h0003);
    ov_fault_pin <= 1'h0;
    wt(3);
    clr();
    ov_alert_mask <= 1'h0;
    c(1, CSO_CMD_CAL_OFFSET, 16'h0425);
    c(1, CSO_CMD_OV_ACTION, 16'h0080);
    c(1, CSO_CMD_STORE_ALL, 16'h0000);
    seen = nvm_store;
    wt(1);
    seen |= nvm_store;
    chk(seen, 16'h0001);
    chk({nvm_cal_out, nvm_ov_out}, {7'h0, 7'h65, 2'h2});
    nvm_cal_in <= 7'h1f;
    nvm_ov_in <= 2'h1;
    nvm_load <= 1'h1;
    wt(1);
    nvm_load <= 1'h0;
    c(0, CSO_CMD_OV_ACTION, 16'h0000);
    chk(rd, 16'h003f);
    c(0, CSO_CMD_CAL_OFFSET, 16'h0000);
    chk(rd, 16'he01f);
    loop_slave_pin <= 1'h1;
    wt(3);
    c(0, CSO_CMD_OV_ACTION, 16'h0000);
    chk(ak, 16'h0000);
    wt(2);
    chk({invalid_command_fault, smbalert_oe_n}, 16'h0002);
    c(1, CSO_CMD_OV_ACTION, 16'h0080);
    chk(ak, 16'h0000);
    loop_slave_pin <= 1'h0;
    wt(3);
    c(0, CSO_CMD_OV_ACTION, 16'h0000);
    chk(rd, 16'h003f);
    c(0, 8'h20, 16'h0000);
    chk(ak, 16'h0000);
    tally_and_finish();
  end
endmodule : current_offset_ov_response_regs_tb
`default_nettype wire
